// >>> hdl/dcfm_regs.svh
// Constants of the replay mailbox queue: depth, offsets and timing counts
`ifndef DCFM_REGS_SVH
`define DCFM_REGS_SVH
`define DCFM_DEPTH 10'd512
`define DCFM_ADDR_W 9
`define DCFM_PTR_ONE 10'd1
`define DCFM_OFS_PRESET 10'd8
`define DCFM_OFS_X_LSB 0
`define DCFM_OFS_Y_LSB 9
`define DCFM_SERIAL_BITS 5'd18
`define DCFM_SERIAL_ONE 5'd1
`define DCFM_REPLAY_MIN_READS 2'd2
`define DCFM_RD_CNT_ONE 2'd1
`endif

// >>> hdl/dcfm_pkg.sv
// Types shared by the replay mailbox queue
package dcfm_pkg;
    typedef struct packed {
        logic select_n;
        logic direction;
        logic transfer_gate;
        logic mail_sel;
        logic [35:0] bus;
    } dcfm_port_t;
    typedef struct packed {
        logic replay_hold_mode;
        logic replay_start;
        logic preset_sel;
        logic serial_en;
        logic serial_bit;
    } dcfm_misc_t;
endpackage

// >>> hdl/dcfm_top.sv
// Replay mailbox queue: 512x36 memory, replay mode, mailboxes, stage FIFO
`timescale 1ns/100ps
`include "dcfm_regs.svh"

module dcfm_stage_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] buf_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = wr_q != rd_q;
    assign out_data = buf_q[rd_q[AW-1:0]];
    always_ff @(posedge clk)
    begin
        if (push)
            buf_q[wr_q[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

// Contract
// R01 - Almost-full low at 512 minus Y words
// R02 - Y preset at reset, or port/serial load
// R03 - Word in output register counts as read
// R04 - Almost-full rises on second write-side edge
// R05 - Late edges push synchronising one cycle later
// R06 - Replay entered with hold and output-ready high
// R07 - Replay ends on edge with hold low
// R08 - Replay start after two reads reloads word
// R09 - Controller keeps replay-start low at exit
// R10 - Shadow pointer frozen; drives input-ready, almost-full
// R11 - Writes continue in replay, flags use shadow
// R12 - Replay start copies shadow, output-ready immediate
// R13 - On exit flags switch, rise synchronised
// R14 - Port A mail write stores mailbox one
// R15 - Port B mail write stores mailbox two
// R16 - Mail write lowers flag; blocked while low
// R17 - Bus outputs select queue or mailbox; the port A bus always drives mailbox two
// R18 - Port B mail read raises flag one
// R19 - Port A mail read raises flag two
// R20 - Mailbox contents kept after read
// R21 - Writes ignored until programming completes
// R22 - Preset option loads X and Y eight
// R23 - First word falls through in three edges
// R24 - Almost-empty low at X or fewer
// R25 - Writes ignored while input-ready low
// R26 - Reads ignored while output-ready low
// R27 - 512 words, pointers wrap modulo depth
// R28 - Reset clears pointers, replay, mailbox flags
module dcfm_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic write_side_clock,
    input wire logic read_side_clock,
    input wire dcfm_pkg::dcfm_port_t port_a_in,
    input wire dcfm_pkg::dcfm_port_t port_b_in,
    input wire dcfm_pkg::dcfm_misc_t misc_in,
    output logic [35:0] port_a_bus_out,
    output logic port_a_bus_oe,
    output logic [35:0] port_b_bus_out,
    output logic port_b_bus_oe,
    output logic input_ready,
    output logic almost_full_n,
    output logic output_ready,
    output logic almost_empty_n,
    output logic mailbox_one_flag_n,
    output logic mailbox_two_flag_n
);
    import dcfm_pkg::*;

    // Pin synchronisers; port clocks become edge pulses on clk
    dcfm_port_t pa_s1, pa_q, pb_s1, pb_q;
    // Released-pin pattern: a zero reset would read as a selected port and pulse port_a_bus_oe
    localparam dcfm_port_t PORT_IDLE = '{select_n: 1'b1, default: '0};
    dcfm_misc_t mi_s1, mi_q;
    logic [2:0] wclk_q, rclk_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pa_s1 <= PORT_IDLE;
            pa_q <= PORT_IDLE;
            pb_s1 <= PORT_IDLE;
            pb_q <= PORT_IDLE;
            mi_s1 <= '0;
            mi_q <= '0;
            // Start high: a port clock already high at release must not look like an edge
            wclk_q <= '1;
            rclk_q <= '1;
        end
        else
        begin
            pa_s1 <= port_a_in;
            pa_q <= pa_s1;
            pb_s1 <= port_b_in;
            pb_q <= pb_s1;
            mi_s1 <= misc_in;
            mi_q <= mi_s1;
            wclk_q <= {wclk_q[1:0], write_side_clock};
            rclk_q <= {rclk_q[1:0], read_side_clock};
        end
    end
    wire a_tick = wclk_q[1] && !wclk_q[2];
    wire b_tick = rclk_q[1] && !rclk_q[2];

    // Port decode
    wire a_sel = !pa_q.select_n && pa_q.transfer_gate;
    wire a_fifo_wr = a_tick && a_sel && pa_q.direction && !pa_q.mail_sel;
    wire a_mail_wr = a_tick && a_sel && pa_q.direction && pa_q.mail_sel;
    wire a_mail_rd = a_tick && a_sel && !pa_q.direction && pa_q.mail_sel;
    wire b_sel = !pb_q.select_n && pb_q.transfer_gate;
    wire b_fifo_rd = b_tick && b_sel && pb_q.direction && !pb_q.mail_sel;
    wire b_mail_rd = b_tick && b_sel && pb_q.direction && pb_q.mail_sel;
    wire b_mail_wr = b_tick && b_sel && !pb_q.direction && pb_q.mail_sel;

    // Queue state
    logic [35:0] mem_q [512];
    logic [9:0] wp_q, rp_q, sp_q;
    logic [35:0] out_q;
    logic or_q, rep_q, ir_q, ir_s1, af_q, af_s1, ae_q, ae_s1, avail_s1, avail_q;
    logic [1:0] rd_cnt_q;
    logic [9:0] ofs_x_q, ofs_y_q;
    logic [4:0] ser_cnt_q;
    logic prog_done_q;
    logic stg_in_ready, stg_valid;
    logic [35:0] stg_data;

    // Output register holds a read word, so counts exclude it
    wire [9:0] cnt_cur = wp_q - rp_q; // R03
    wire [9:0] flag_base = rep_q ? sp_q : rp_q; // R10 R13
    wire [9:0] cnt_sh = wp_q - flag_base;
    wire wr_ok = a_fifo_wr && ir_q && prog_done_q; // R21 R25
    wire [9:0] cnt_a_next = cnt_sh + 10'(wr_ok);
    wire ir_raw = (cnt_a_next < `DCFM_DEPTH) && stg_in_ready && prog_done_q;
    wire af_raw = cnt_a_next <= (`DCFM_DEPTH - ofs_y_q - `DCFM_PTR_ONE); // R01
    wire rd_ok = b_fifo_rd && or_q; // R26
    wire replay_go = rep_q && mi_q.replay_hold_mode && mi_q.replay_start
        && (rd_cnt_q >= `DCFM_REPLAY_MIN_READS);
    wire load_next = b_tick && !replay_go && (cnt_cur != 10'd0) && avail_q
        && (!or_q || rd_ok);
    wire [9:0] cnt_b_next = cnt_cur - 10'(load_next);
    wire ae_raw = cnt_b_next > ofs_x_q; // R24
    wire drain = stg_valid && (cnt_sh != `DCFM_DEPTH);

    dcfm_stage_fifo #(.WIDTH(36), .DEPTH(16)) u_stage (
        .clk(clk),
        .rst(rst),
        .in_valid(wr_ok),
        .in_ready(stg_in_ready),
        .in_data(pa_q.bus),
        .out_valid(stg_valid),
        .out_ready(drain),
        .out_data(stg_data)
    );

    always_ff @(posedge clk)
    begin
        if (drain)
            mem_q[wp_q[`DCFM_ADDR_W-1:0]] <= stg_data; // R27
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wp_q <= '0; // R28
        else if (drain)
            wp_q <= wp_q + `DCFM_PTR_ONE; // R27
    end

    // Offset programming; preset strap caught after reset release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ofs_x_q <= `DCFM_OFS_PRESET;
            ofs_y_q <= `DCFM_OFS_PRESET;
            ser_cnt_q <= '0;
            prog_done_q <= 1'b0;
        end
        else if (!prog_done_q)
        begin
            if (mi_q.preset_sel)
                prog_done_q <= 1'b1; // R22
            else if (a_tick && mi_q.serial_en)
            begin
                {ofs_x_q[8:0], ofs_y_q[8:0]} <= {ofs_x_q[7:0], ofs_y_q[8:0], mi_q.serial_bit};
                ser_cnt_q <= ser_cnt_q + `DCFM_SERIAL_ONE; // R02
                prog_done_q <= (ser_cnt_q + `DCFM_SERIAL_ONE) == `DCFM_SERIAL_BITS;
            end
            else if (a_fifo_wr)
            begin
                ofs_x_q <= {1'b0, pa_q.bus[`DCFM_OFS_X_LSB +: 9]}; // R02
                ofs_y_q <= {1'b0, pa_q.bus[`DCFM_OFS_Y_LSB +: 9]};
                prog_done_q <= 1'b1;
            end
        end
    end

    // Write-side flags: falls at once, rises after two write-side edges
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ir_s1 <= 1'b0;
            ir_q <= 1'b0;
            af_s1 <= 1'b1;
            af_q <= 1'b1;
        end
        else if (a_tick)
        begin
            ir_s1 <= ir_raw;
            ir_q <= ir_raw && ir_s1; // R11 R13 R25
            af_s1 <= af_raw;
            af_q <= af_raw && af_s1; // R01 R04 R05 R11 R13
        end
    end

    // Read side: output register, replay and almost-empty
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rp_q <= '0;
            sp_q <= '0;
            rep_q <= 1'b0;
            or_q <= 1'b0;
            out_q <= '0;
            rd_cnt_q <= '0;
            avail_s1 <= 1'b0;
            avail_q <= 1'b0;
            ae_s1 <= 1'b0;
            ae_q <= 1'b0;
        end
        else if (b_tick)
        begin
            avail_s1 <= cnt_cur != 10'd0;
            avail_q <= avail_s1 && (cnt_cur != 10'd0); // R23
            ae_s1 <= ae_raw;
            ae_q <= ae_raw && ae_s1; // R24 R12
            if (!rep_q && mi_q.replay_hold_mode && or_q)
            begin
                rep_q <= 1'b1; // R06
                sp_q <= rp_q - `DCFM_PTR_ONE;
                rd_cnt_q <= '0;
            end
            else if (rep_q && !mi_q.replay_hold_mode)
                rep_q <= 1'b0; // R07 R09
            if (replay_go)
            begin
                out_q <= mem_q[sp_q[`DCFM_ADDR_W-1:0]]; // R08
                rp_q <= sp_q + `DCFM_PTR_ONE; // R12
                or_q <= 1'b1;
                rd_cnt_q <= '0;
            end
            else if (load_next)
            begin
                out_q <= mem_q[rp_q[`DCFM_ADDR_W-1:0]]; // R23
                rp_q <= rp_q + `DCFM_PTR_ONE; // R27
                or_q <= 1'b1;
                if (rd_ok && rep_q && rd_cnt_q != `DCFM_REPLAY_MIN_READS)
                    rd_cnt_q <= rd_cnt_q + `DCFM_RD_CNT_ONE;
            end
            else if (rd_ok)
                or_q <= 1'b0; // R26
        end
    end

    // Mailboxes; a write in the clearing cycle is blocked while the flag is low, so the flag still rises
    logic [35:0] mb1_q, mb2_q;
    logic mailbox_one_flag_n_q, mailbox_two_flag_n_q;
    wire mb1_wr = a_mail_wr && mailbox_one_flag_n_q; // R16
    wire mb2_wr = b_mail_wr && mailbox_two_flag_n_q; // R16
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mb1_q <= '0;
            mb2_q <= '0;
            mailbox_one_flag_n_q <= 1'b1; // R28
            mailbox_two_flag_n_q <= 1'b1;
        end
        else
        begin
            if (mb1_wr)
                mb1_q <= pa_q.bus; // R14 R20
            if (mb2_wr)
                mb2_q <= pb_q.bus; // R15 R20
            if (mb1_wr)
                mailbox_one_flag_n_q <= 1'b0; // R16
            else if (b_mail_rd)
                mailbox_one_flag_n_q <= 1'b1; // R18
            if (mb2_wr)
                mailbox_two_flag_n_q <= 1'b0; // R16
            else if (a_mail_rd)
                mailbox_two_flag_n_q <= 1'b1; // R19
        end
    end

    // Registered pin outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_a_bus_out <= '0;
            port_a_bus_oe <= 1'b0;
            port_b_bus_out <= '0;
            port_b_bus_oe <= 1'b0;
        end
        else
        begin
            port_a_bus_out <= mb2_q; // R17
            port_a_bus_oe <= !pa_q.select_n && !pa_q.direction;
            port_b_bus_out <= pb_q.mail_sel ? mb1_q : out_q; // R17
            port_b_bus_oe <= !pb_q.select_n && pb_q.direction;
        end
    end
    assign input_ready = ir_q;
    assign almost_full_n = af_q;
    assign output_ready = or_q;
    assign almost_empty_n = ae_q;
    assign mailbox_one_flag_n = mailbox_one_flag_n_q;
    assign mailbox_two_flag_n = mailbox_two_flag_n_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_enter;
        b_tick && !rep_q && mi_q.replay_hold_mode && or_q;
    endsequence
    property p_af_low;
        a_tick && !af_raw |=> !almost_full_n;
    endproperty
    a_af_low: assert property (p_af_low) else $error("almost-full not low"); // R01
    property p_af_rise;
        a_tick && !af_q && af_raw && !af_s1 |=> !almost_full_n;
    endproperty
    a_af_rise: assert property (p_af_rise) else $error("almost-full rose early"); // R04
    property p_rep_enter;
        s_enter |=> rep_q && sp_q == $past(rp_q) - `DCFM_PTR_ONE;
    endproperty
    a_rep_enter: assert property (p_rep_enter) else $error("replay entry wrong"); // R06
    property p_rep_exit;
        b_tick && rep_q && !mi_q.replay_hold_mode |=> !rep_q;
    endproperty
    a_rep_exit: assert property (p_rep_exit) else $error("replay not left"); // R07
    property p_shadow;
        rep_q && $past(rep_q) |-> $stable(sp_q);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow pointer moved"); // R10
    property p_restart;
        b_tick && replay_go |=> output_ready && rp_q == $past(sp_q) + `DCFM_PTR_ONE;
    endproperty
    a_restart: assert property (p_restart) else $error("replay start wrong"); // R12
    property p_mb1_block;
        a_mail_wr && !mailbox_one_flag_n_q |=> $stable(mb1_q);
    endproperty
    a_mb1_block: assert property (p_mb1_block) else $error("mailbox one overwritten"); // R16
    property p_mailbox_one_flag_n_clear;
        b_mail_rd && !mb1_wr |=> mailbox_one_flag_n;
    endproperty
    a_mailbox_one_flag_n_clear: assert property (p_mailbox_one_flag_n_clear) else $error("flag one not raised"); // R18
    property p_mailbox_two_flag_n_clear;
        a_mail_rd && !mb2_wr |=> mailbox_two_flag_n;
    endproperty
    a_mailbox_two_flag_n_clear: assert property (p_mailbox_two_flag_n_clear) else $error("flag two not raised"); // R19
    property p_no_write_full;
        !input_ready |-> !wr_ok;
    endproperty
    a_no_write_full: assert property (p_no_write_full) else $error("write while full"); // R25
    property p_or_hold;
        b_tick && !or_q && !load_next && !replay_go |=> $stable(out_q) ##1 $stable(out_q);
    endproperty
    a_or_hold: assert property (p_or_hold) else $error("output register changed"); // R26
endmodule

// >>> dv/dcfm_port_host.sv
// Far-side host model: free-running clocks of both ports
`timescale 1ns/100ps
module dcfm_port_host (
    input wire logic clk,
    output logic write_side_clock,
    output logic read_side_clock
);
    logic [1:0] a_cnt_q = 2'h0;
    logic [2:0] b_cnt_q = 3'h0;
    // Unequal periods keep the ports out of step; every phase lasts two clk or more
    // so the pin synchronisers never miss an edge
    always_ff @(posedge clk)
    begin
        a_cnt_q <= a_cnt_q + 2'h1;
        b_cnt_q <= (b_cnt_q == 3'h5) ? 3'h0 : b_cnt_q + 3'h1;
    end
    assign write_side_clock = a_cnt_q[1];
    assign read_side_clock = (b_cnt_q > 3'h2);
endmodule

// >>> dv/dcfm_top_tb.sv
// Directed bench for the replay mailbox queue
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end
`define WAITFOR(c) begin wk = 0; while (((c) !== 1'b1) && (wk < 300)) begin \
    @(posedge clk); wk++; end if ((c) !== 1'b1) timeout(); end

module dcfm_top_tb;
    import dcfm_pkg::*;
    localparam dcfm_port_t IDLE_P = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pre = 1'b1;
    dcfm_port_t port_a_in = IDLE_P;
    dcfm_port_t port_b_in = IDLE_P;
    dcfm_misc_t misc_in = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic write_side_clock, read_side_clock;
    logic [35:0] port_a_bus_out, port_b_bus_out;
    logic port_a_bus_oe, port_b_bus_oe, input_ready, almost_full_n, output_ready;
    logic almost_empty_n, mailbox_one_flag_n, mailbox_two_flag_n;
    int num_errors = 0;
    int n_checks = 0;
    int wk;
    int i;

    always #2 clk = ~clk;

    dcfm_port_host dcfm_port_host_i (.clk(clk), .write_side_clock(write_side_clock),
        .read_side_clock(read_side_clock));

    dcfm_top dcfm_top_i (.clk(clk), .rst(rst), .write_side_clock(write_side_clock),
        .read_side_clock(read_side_clock), .port_a_in(port_a_in), .port_b_in(port_b_in),
        .misc_in(misc_in), .port_a_bus_out(port_a_bus_out), .port_a_bus_oe(port_a_bus_oe),
        .port_b_bus_out(port_b_bus_out), .port_b_bus_oe(port_b_bus_oe),
        .input_ready(input_ready), .almost_full_n(almost_full_n),
        .output_ready(output_ready), .almost_empty_n(almost_empty_n),
        .mailbox_one_flag_n(mailbox_one_flag_n), .mailbox_two_flag_n(mailbox_two_flag_n));

    function automatic dcfm_port_t mk(logic sn, logic dir, logic g, logic m, logic [35:0] d);
        mk = '{sn, dir, g, m, d};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if ((num_errors == 0) && (n_checks > 0))
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic timeout();
        num_errors++;
        $display("MISMATCH at %0t: wait ran out", $time);
        finish_test();
    endtask

    // Pins change just after the port clock falls and stand for one whole port cycle
    task automatic a_op(dcfm_port_t p);
        @(negedge write_side_clock);
        port_a_in <= p;
    endtask

    task automatic b_op(dcfm_port_t p, logic h, logic s);
        @(negedge read_side_clock);
        port_b_in <= p;
        misc_in <= '{h, s, pre, 1'b0, 1'b0};
    endtask

    // One port B cycle, then idle cycles so the flags and the bus settle
    task automatic rd(logic h, logic s, logic g);
        b_op(mk(1'b0, 1'b1, g, 1'b0, 36'h0), h, s);
        b_op(IDLE_P, h, 1'b0);
        b_op(IDLE_P, h, 1'b0);
        repeat (6) @(posedge clk);
    endtask

    task automatic do_reset(logic p);
        rst <= 1'b1;
        pre <= p;
        misc_in <= '{1'b0, 1'b0, p, 1'b0, 1'b0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(mailbox_one_flag_n, 1'b1)
        `CHK(mailbox_two_flag_n, 1'b1)
        `CHK(almost_full_n, 1'b1)
        `CHK(input_ready, 1'b0)
        `CHK(output_ready, 1'b0)
        `CHK(almost_empty_n, 1'b0)
        `CHK(port_a_bus_oe, 1'b0)
    endtask

    // Serial offsets: one bit per port A cycle, X then Y, top bit first
    task automatic ser_prog(logic [17:0] v);
        for (int k = 17; k >= 0; k--)
        begin
            @(negedge write_side_clock);
            misc_in <= '{1'b0, 1'b0, 1'b0, 1'b1, v[k]};
        end
        @(negedge write_side_clock);
        misc_in <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        timeout();
    end

    initial
    begin
        do_reset(1'b1);
        `WAITFOR(input_ready)
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b1, 36'h0a5a5a5a5));
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b1, 36'h0ffff0000));
        a_op(IDLE_P);
        a_op(IDLE_P);
        `CHK(mailbox_one_flag_n, 1'b0)
        b_op(mk(1'b0, 1'b1, 1'b0, 1'b1, 36'h0), 1'b0, 1'b0);
        b_op(mk(1'b0, 1'b1, 1'b0, 1'b1, 36'h0), 1'b0, 1'b0);
        `CHK(port_b_bus_out, 36'h0a5a5a5a5)
        `CHK(port_b_bus_oe, 1'b1)
        b_op(mk(1'b0, 1'b1, 1'b1, 1'b1, 36'h0), 1'b0, 1'b0);
        b_op(mk(1'b0, 1'b1, 1'b0, 1'b1, 36'h0), 1'b0, 1'b0);
        b_op(mk(1'b0, 1'b1, 1'b0, 1'b1, 36'h0), 1'b0, 1'b0);
        `CHK(mailbox_one_flag_n, 1'b1)
        `CHK(port_b_bus_out, 36'h0a5a5a5a5)
        b_op(mk(1'b0, 1'b0, 1'b1, 1'b1, 36'h0c3c3c3c3), 1'b0, 1'b0);
        b_op(IDLE_P, 1'b0, 1'b0);
        b_op(IDLE_P, 1'b0, 1'b0);
        `CHK(mailbox_two_flag_n, 1'b0)
        a_op(mk(1'b0, 1'b0, 1'b0, 1'b1, 36'h0));
        a_op(mk(1'b0, 1'b0, 1'b0, 1'b1, 36'h0));
        `CHK(port_a_bus_out, 36'h0c3c3c3c3)
        `CHK(port_a_bus_oe, 1'b1)
        a_op(mk(1'b0, 1'b0, 1'b1, 1'b1, 36'h0));
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b1, 36'h012345678));
        a_op(IDLE_P);
        a_op(IDLE_P);
        `CHK(mailbox_two_flag_n, 1'b1)
        $display("mailbox test done");
        // Left full on purpose so the second reset has a flag to restore
        `CHK(mailbox_one_flag_n, 1'b0)
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h0));
        a_op(IDLE_P);
        repeat (6) @(posedge clk);
        `CHK(output_ready, 1'b0)
        `WAITFOR(output_ready)
        for (i = 1; i < 513; i++)
            a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'(i)));
        a_op(IDLE_P);
        repeat (4) @(posedge clk);
        `CHK(input_ready, 1'b0)
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h0dead));
        a_op(IDLE_P);
        repeat (12) @(posedge clk);
        for (i = 0; i < 513; i++)
        begin
            `CHK(port_b_bus_out, 36'(i))
            `CHK(almost_full_n, ((512 - i) < 504))
            `CHK(almost_empty_n, ((512 - i) > 8))
            rd(1'b0, 1'b0, 1'b1);
        end
        `CHK(output_ready, 1'b0)
        rd(1'b0, 1'b0, 1'b1);
        `CHK(port_b_bus_out, 36'd512)
        $display("fill and drain test done");
        do_reset(1'b0);
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h000001002));
        a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h0bad));
        a_op(IDLE_P);
        `WAITFOR(input_ready)
        for (i = 0; i < 5; i++)
        begin
            a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h100 + 36'(i)));
            if (i == 2)
            begin
                a_op(IDLE_P);
                `WAITFOR(output_ready)
                repeat (30) @(posedge clk);
                `CHK(almost_empty_n, 1'b0)
            end
        end
        a_op(IDLE_P);
        repeat (30) @(posedge clk);
        `CHK(almost_empty_n, 1'b1)
        rd(1'b1, 1'b0, 1'b0);
        `CHK(port_b_bus_out, 36'h100)
        rd(1'b1, 1'b0, 1'b1);
        `CHK(port_b_bus_out, 36'h101)
        rd(1'b1, 1'b0, 1'b1);
        `CHK(port_b_bus_out, 36'h102)
        rd(1'b1, 1'b1, 1'b0);
        `CHK(port_b_bus_out, 36'h100)
        `CHK(output_ready, 1'b1)
        rd(1'b1, 1'b0, 1'b1);
        `CHK(port_b_bus_out, 36'h101)
        // Replay start stays low on the leaving edge
        rd(1'b0, 1'b0, 1'b0);
        rd(1'b0, 1'b0, 1'b1);
        `CHK(port_b_bus_out, 36'h102)
        `CHK(input_ready, 1'b1)
        // Had replay stayed on, two reads would make this a replay start instead of an entry
        rd(1'b1, 1'b1, 1'b0);
        `CHK(port_b_bus_out, 36'h102)
        $display("replay test done");
        do_reset(1'b0);
        ser_prog(18'h003fe);
        `WAITFOR(input_ready)
        `CHK(almost_full_n, 1'b1)
        for (i = 0; i < 3; i++)
            a_op(mk(1'b0, 1'b1, 1'b1, 1'b0, 36'h200 + 36'(i)));
        a_op(IDLE_P);
        repeat (40) @(posedge clk);
        `CHK(output_ready, 1'b1)
        `CHK(port_b_bus_out, 36'h200)
        `CHK(almost_full_n, 1'b0)
        `CHK(almost_empty_n, 1'b1)
        $display("serial offset test done");
        finish_test();
    end
endmodule
